// ---- inc/lsbf_pkg.sv ----
// Constants, register layouts and helper functions for the LED sink blink and fade timing block.
// Assumes a serial register interface outside this block that delivers decoded byte accesses.
package lsbf_pkg;

	// ==========================================================
	// Register offsets and values after reset
	localparam logic [7:0] LSBF_ADDR_SINK_ENABLE = 8'h10;
	localparam logic [7:0] LSBF_ADDR_TIME_HIGH = 8'h11;
	localparam logic [7:0] LSBF_ADDR_TIME_LOW = 8'h12;
	localparam logic [7:0] LSBF_ADDR_FADE = 8'h13;
	localparam logic [7:0] LSBF_RESET_VALUE = 8'h00;
	localparam int LSBF_SINKS = 7;

	// ==========================================================
	// Field layouts, most significant field first
	typedef struct packed {
		logic reserved;
		logic [6:0] sink_enable_bit;
	} lsbf_enable_reg_t;

	typedef struct packed {
		logic [1:0] shared_on_time;
		logic [1:0] sink7_off_time;
		logic [1:0] sink6_off_time;
		logic [1:0] sink5_off_time;
	} lsbf_time_high_reg_t;

	typedef struct packed {
		logic [1:0] sink4_off_time;
		logic [1:0] sink3_off_time;
		logic [1:0] sink2_off_time;
		logic [1:0] sink1_off_time;
	} lsbf_time_low_reg_t;

	typedef struct packed {
		logic [3:0] fade_out_rate;
		logic [3:0] fade_in_rate;
	} lsbf_fade_reg_t;

	// ==========================================================
	// Timing: on, off and fade durations are counted in 1 ms ticks
	localparam int LSBF_CLK_PERIOD_NS = 4;
	localparam int LSBF_TICK_TIME_NS = 1000000;
	localparam int LSBF_TICK_CYCLES = LSBF_TICK_TIME_NS / LSBF_CLK_PERIOD_NS;
	localparam int LSBF_OFF_UNIT_MS = 600;
	localparam int LSBF_ON_00_MS = 200;
	localparam int LSBF_ON_01_MS = 600;
	localparam int LSBF_ON_10_MS = 800;
	localparam int LSBF_ON_11_MS = 1200;
	localparam int LSBF_FADE_STEP_MS = 300;
	localparam int LSBF_FADE_LAST_LINEAR = 9;
	localparam int LSBF_FADE_HIGH_BASE_MS = 3000;
	localparam int LSBF_FADE_HIGH_STEP_MS = 500;
	localparam logic [6:0] LSBF_FULL_LEVEL = 7'h7f;

	typedef enum logic {
		LSBF_ON_PHASE,
		LSBF_OFF_PHASE
	} lsbf_phase_t;

	typedef struct packed {
		lsbf_phase_t phase;
		logic [12:0] timer;
		logic [13:0] acc;
		logic [6:0] level;
		logic lit;
	} lsbf_chan_state_t;

	typedef struct packed {
		lsbf_enable_reg_t enables;
		lsbf_time_high_reg_t time_high;
		lsbf_time_low_reg_t time_low;
		lsbf_fade_reg_t fade;
		logic [31:0] prescale;
		logic ms_tick;
		logic [7:0] rdata;
		logic rvalid;
	} lsbf_top_state_t;

	// ==========================================================
	// Code to duration decoders
	function automatic logic [12:0] lsbf_off_ms(input logic [1:0] code);
		return 13'(int'(code) * LSBF_OFF_UNIT_MS);
	endfunction : lsbf_off_ms

	function automatic logic [12:0] lsbf_on_ms(input logic [1:0] code);
		case (code)
			2'h0: return 13'(LSBF_ON_00_MS);
			2'h1: return 13'(LSBF_ON_01_MS);
			2'h2: return 13'(LSBF_ON_10_MS);
			default: return 13'(LSBF_ON_11_MS);
		endcase
	endfunction : lsbf_on_ms

	// Zero means the fade is disabled
	function automatic logic [12:0] lsbf_fade_ms(input logic [3:0] code);
		if (int'(code) <= LSBF_FADE_LAST_LINEAR) begin
			return 13'(int'(code) * LSBF_FADE_STEP_MS);
		end
		return 13'(LSBF_FADE_HIGH_BASE_MS
			+ (int'(code) - LSBF_FADE_LAST_LINEAR - 1) * LSBF_FADE_HIGH_STEP_MS);
	endfunction : lsbf_fade_ms

endpackage : lsbf_pkg

// ---- src/lsbf_sink_channel.sv ----
// One sink channel: blink phase timer and linear current ramp.
// Assumes a one-cycle 1 ms tick and static configuration from the register block.
module lsbf_sink_channel (
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	input wire logic ms_tick_in,
	// Configuration
	input wire logic enable_in,
	input wire logic [1:0] off_code_in,
	input wire logic [1:0] on_code_in,
	input wire logic [12:0] fade_in_ms_in,
	input wire logic [12:0] fade_out_ms_in,
	// Drive
	output logic lit_out,
	output logic [6:0] level_out
);
	lsbf_pkg::lsbf_chan_state_t s;
	lsbf_pkg::lsbf_chan_state_t next_s;

	// ==========================================================
	// Next state
	always_comb begin
		logic [6:0] target;
		logic [12:0] rate;
		logic [13:0] sum;
		target = 7'h00;
		rate = 13'h0000;
		sum = 14'h0000;
		next_s = s;
		if (!enable_in) begin
			next_s.phase = lsbf_pkg::LSBF_ON_PHASE;
			next_s.timer = 13'h0000;
		end else if (off_code_in == 2'h0) begin
			next_s.phase = lsbf_pkg::LSBF_ON_PHASE;
			next_s.timer = 13'h0000;
		end else if (ms_tick_in) begin
			next_s.timer = s.timer + 13'h0001;
			case (s.phase)
				lsbf_pkg::LSBF_ON_PHASE: begin
					if (next_s.timer >= lsbf_pkg::lsbf_on_ms(on_code_in)) begin
						next_s.phase = lsbf_pkg::LSBF_OFF_PHASE;
						next_s.timer = 13'h0000;
					end
				end
				lsbf_pkg::LSBF_OFF_PHASE: begin
					if (next_s.timer >= lsbf_pkg::lsbf_off_ms(off_code_in)) begin
						next_s.phase = lsbf_pkg::LSBF_ON_PHASE;
						next_s.timer = 13'h0000;
					end
				end
				default: begin
					next_s.phase = lsbf_pkg::LSBF_ON_PHASE;
				end
			endcase
		end
		next_s.lit = enable_in && (next_s.phase == lsbf_pkg::LSBF_ON_PHASE);
		// Ramp one level per overflow so any partial fade keeps the full-scale slope
		target = s.lit ? lsbf_pkg::LSBF_FULL_LEVEL : 7'h00;
		rate = (target > s.level) ? fade_in_ms_in : fade_out_ms_in;
		sum = s.acc + 14'(lsbf_pkg::LSBF_FULL_LEVEL);
		if (s.level == target) begin
			next_s.acc = 14'h0000;
		end else if (rate == 13'h0000) begin
			next_s.level = target;
			next_s.acc = 14'h0000;
		end else if (ms_tick_in) begin
			if (sum >= 14'(rate)) begin
				next_s.acc = sum - 14'(rate);
				next_s.level = (target > s.level) ? s.level + 7'h01 : s.level - 7'h01;
			end else begin
				next_s.acc = sum;
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s <= '0;
		end else if (ce_in) begin
			s <= next_s;
		end
	end

	assign lit_out = s.lit;
	assign level_out = s.level;

endmodule : lsbf_sink_channel

// ---- src/lsbf_sink_timing.sv ----
// Register file and seven sink channels of the independent sink timing block.
// Assumes the serial interface presents decoded single-byte reads and writes on clk_in.
module lsbf_sink_timing #(
	parameter int TICK_CYCLES = lsbf_pkg::LSBF_TICK_CYCLES
) (
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	// Register access from the serial interface
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// Sink drive
	output logic [6:0] sink_lit_out,
	output logic [48:0] sink_level_out
);
	lsbf_pkg::lsbf_top_state_t s;
	lsbf_pkg::lsbf_top_state_t next_s;
	logic [1:0] off_code [lsbf_pkg::LSBF_SINKS];
	logic [12:0] fade_in_ms;
	logic [12:0] fade_out_ms;

	// ==========================================================
	// Field extraction
	always_comb begin
		off_code[0] = s.time_low.sink1_off_time;
		off_code[1] = s.time_low.sink2_off_time;
		off_code[2] = s.time_low.sink3_off_time;
		off_code[3] = s.time_low.sink4_off_time;
		off_code[4] = s.time_high.sink5_off_time;
		off_code[5] = s.time_high.sink6_off_time;
		off_code[6] = s.time_high.sink7_off_time;
		fade_in_ms = lsbf_pkg::lsbf_fade_ms(s.fade.fade_in_rate);
		fade_out_ms = lsbf_pkg::lsbf_fade_ms(s.fade.fade_out_rate);
	end

	// ==========================================================
	// Registers, read port and millisecond prescaler
	always_comb begin
		next_s = s;
		next_s.rvalid = reg_read_in;
		if (reg_read_in) begin
			case (reg_addr_in)
				lsbf_pkg::LSBF_ADDR_SINK_ENABLE: next_s.rdata = {1'b0, s.enables.sink_enable_bit};
				lsbf_pkg::LSBF_ADDR_TIME_HIGH: next_s.rdata = s.time_high;
				lsbf_pkg::LSBF_ADDR_TIME_LOW: next_s.rdata = s.time_low;
				lsbf_pkg::LSBF_ADDR_FADE: next_s.rdata = s.fade;
				default: next_s.rdata = 8'h00;
			endcase
		end
		if (reg_write_in) begin
			case (reg_addr_in)
				lsbf_pkg::LSBF_ADDR_SINK_ENABLE: begin
					next_s.enables = {1'b0, reg_wdata_in[6:0]};
				end
				lsbf_pkg::LSBF_ADDR_TIME_HIGH: next_s.time_high = reg_wdata_in;
				lsbf_pkg::LSBF_ADDR_TIME_LOW: next_s.time_low = reg_wdata_in;
				lsbf_pkg::LSBF_ADDR_FADE: next_s.fade = reg_wdata_in;
				default: begin
				end
			endcase
		end
		// Coarse shared tick keeps the per-sink counters narrow
		if (s.prescale >= 32'(TICK_CYCLES - 1)) begin
			next_s.prescale = 32'h0000_0000;
			next_s.ms_tick = 1'b1;
		end else begin
			next_s.prescale = s.prescale + 32'h0000_0001;
			next_s.ms_tick = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s <= '0;
			s.enables <= lsbf_pkg::LSBF_RESET_VALUE;
			s.time_high <= lsbf_pkg::LSBF_RESET_VALUE;
			s.time_low <= lsbf_pkg::LSBF_RESET_VALUE;
			s.fade <= lsbf_pkg::LSBF_RESET_VALUE;
		end else if (ce_in) begin
			s <= next_s;
		end
	end

	assign reg_rdata_out = s.rdata;
	assign reg_rvalid_out = s.rvalid;

	// ==========================================================
	// Sink channels
	for (genvar i = 0; i < lsbf_pkg::LSBF_SINKS; i++) begin : g_sink
		lsbf_sink_channel u_chan (
			.clk_in(clk_in),
			.reset_in(reset_in),
			.ce_in(ce_in),
			.ms_tick_in(s.ms_tick),
			.enable_in(s.enables.sink_enable_bit[i]),
			.off_code_in(off_code[i]),
			.on_code_in(s.time_high.shared_on_time),
			.fade_in_ms_in(fade_in_ms),
			.fade_out_ms_in(fade_out_ms),
			.lit_out(sink_lit_out[i]),
			.level_out(sink_level_out[i*7 +: 7])
		);
	end

endmodule : lsbf_sink_timing

// ---- testbench/lsbf_host_model.sv ----
// Host model issuing single-byte register reads and writes.
// Assumes the read answer arrives one cycle after the strobe.
module lsbf_host_model (
	// Clock
	input wire logic clk_in,
	// Register access
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	output logic write_out,
	output logic read_out,
	input wire logic [7:0] rdata_in,
	input wire logic rvalid_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		write_out = 1'b0;
		read_out = 1'b0;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d;
		write_out = 1'b1;
		@(negedge clk_in);
		write_out = 1'b0;
		// Released data must not look like a held value
		wdata_out = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		read_out = 1'b1;
		@(negedge clk_in);
		read_out = 1'b0;
		d = rvalid_in ? rdata_in : 8'hxx;
	endtask : rd
endmodule : lsbf_host_model

// ---- testbench/lsbf_sink_timing_properties.sv ----
// Port checker for the sink timing block.
// Assumes one clock domain and a bind onto lsbf_sink_timing.
module lsbf_sink_timing_properties (
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic ce_in,
	// Registers
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	// Sinks
	input wire logic [6:0] sink_lit_out,
	input wire logic [48:0] sink_level_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// ========
	// Register port
	chk_read_answered: assert property (ce_in && reg_read_in |=> reg_rvalid_out)
		else $error("read not answered");
	chk_no_stray_valid: assert property (ce_in && !reg_read_in |=> !reg_rvalid_out)
		else $error("stray read valid");
	chk_rdata_holds: assert property (!(ce_in && reg_read_in) |=> $stable(reg_rdata_out))
		else $error("read data moved");
	chk_unmapped_zero: assert property (
		ce_in && reg_read_in && !(reg_addr_in inside {[8'h10:8'h13]})
		|=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	// Host leaves one idle cycle between a write and the following read
	chk_time_readback: assert property (
		(ce_in && reg_write_in && !reg_read_in && reg_addr_in inside {8'h11, 8'h12})
		##1 !reg_write_in
		##1 (ce_in && reg_read_in && !reg_write_in && reg_addr_in == $past(reg_addr_in, 2))
		|=> reg_rdata_out == $past(reg_wdata_in, 3))
		else $error("time register readback");
	chk_fade_readback: assert property (
		(ce_in && reg_write_in && !reg_read_in && reg_addr_in == 8'h13) ##1 !reg_write_in
		##1 (ce_in && reg_read_in && !reg_write_in && reg_addr_in == 8'h13)
		|=> reg_rdata_out == $past(reg_wdata_in, 3))
		else $error("fade register readback");
	chk_enable_readback: assert property (
		(ce_in && reg_write_in && !reg_read_in && reg_addr_in == 8'h10) ##1 !reg_write_in
		##1 (ce_in && reg_read_in && !reg_write_in && reg_addr_in == 8'h10)
		|=> reg_rdata_out == {1'b0, $past(reg_wdata_in[6:0], 3)})
		else $error("enable register readback");
	// ========
	// Sinks
	chk_disable_darkens: assert property (
		(ce_in && reg_write_in && reg_addr_in == 8'h10 && !reg_wdata_in[0]) ##1 ce_in
		|=> !sink_lit_out[0])
		else $error("disabled sink still lit");
endmodule : lsbf_sink_timing_properties

bind lsbf_sink_timing lsbf_sink_timing_properties lsbf_sink_timing_properties_inst (.clk_in,
	.reset_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in,
	.reg_rdata_out, .reg_rvalid_out, .sink_lit_out, .sink_level_out);

// ---- testbench/lsbf_sink_timing_tb.sv ----
// Self-checking bench for the sink timing block.
// Assumes a shortened 4-cycle tick so phase times scale to cycles.
module lsbf_sink_timing_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TC = 4;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [7:0] addr, wdata, rdata, rd;
	logic write, read, rvalid;
	logic [6:0] lit;
	logic [48:0] level;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int n;
	int on_ms[4] = '{200, 600, 800, 1200};
	always #2 clk_in = ~clk_in;
	lsbf_host_model lsbf_host_model_inst (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata),
		.write_out(write), .read_out(read), .rdata_in(rdata), .rvalid_in(rvalid));
	lsbf_sink_timing #(.TICK_CYCLES(TC)) lsbf_sink_timing_inst (.clk_in(clk_in),
		.reset_in(reset_in), .ce_in(1'b1), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.reg_write_in(write), .reg_read_in(read), .reg_rdata_out(rdata),
		.reg_rvalid_out(rvalid), .sink_lit_out(lit), .sink_level_out(level));
	task automatic conclude();
		if (bad_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		lsbf_host_model_inst.rd(a, rd);
		check(16'(rd), 16'(exp));
	endtask : rdchk
	// Cycles spent with sink 1 lit at lvl, capped at 8000
	task automatic span(input logic lvl, output int c);
		c = 0;
		while (lit[0] === lvl && c < 8000) begin
			@(negedge clk_in);
			c++;
		end
	endtask : span
	task automatic ramp(input logic [6:0] t, output int c);
		c = 0;
		while (level[6:0] !== t && c < 20000) begin
			@(negedge clk_in);
			c++;
		end
	endtask : ramp
	task automatic near(input int seen, input int exp);
		check(16'(seen >= exp - 2 * TC && seen <= exp + 2 * TC), 16'h1);
	endtask : near
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			bad_count++;
			conclude();
		end
	end
	initial begin
		repeat (3) @(negedge clk_in);
		reset_in = 1'b0;
		for (int a = 8'h10; a < 8'h14; a++) begin
			rdchk(8'(a), 8'h00);
		end
		lsbf_host_model_inst.wr(8'h12, 8'he4);
		rdchk(8'h12, 8'he4);
		lsbf_host_model_inst.wr(8'h11, 8'h1b);
		rdchk(8'h11, 8'h1b);
		lsbf_host_model_inst.wr(8'h13, 8'h5a);
		rdchk(8'h13, 8'h5a);
		lsbf_host_model_inst.wr(8'h10, 8'hfe);
		rdchk(8'h10, 8'h7e);
		lsbf_host_model_inst.wr(8'h14, 8'hff);
		rdchk(8'h14, 8'h00);
		lsbf_host_model_inst.wr(8'h13, 8'h00);
		// ========
		// Blink: every on code, off codes 1 to 3
		for (int k = 0; k < 4; k++) begin
			lsbf_host_model_inst.wr(8'h10, 8'h00);
			lsbf_host_model_inst.wr(8'h11, 8'(k << 6));
			lsbf_host_model_inst.wr(8'h12, 8'(k == 0 ? 1 : k));
			lsbf_host_model_inst.wr(8'h10, 8'h01);
			repeat (2) @(negedge clk_in);
			check(16'(lit[0]), 16'h1);
			span(1'b1, n);
			near(n, on_ms[k] * TC);
			span(1'b0, n);
			near(n, (k == 0 ? 1 : k) * 600 * TC);
			span(1'b1, n);
			near(n, on_ms[k] * TC);
		end
		lsbf_host_model_inst.wr(8'h10, 8'h00);
		repeat (2) @(negedge clk_in);
		check(16'(lit[0]), 16'h0);
		// Only sinks 3 and 6 blink, so after one on phase just they go dark
		lsbf_host_model_inst.wr(8'h11, 8'h04);
		lsbf_host_model_inst.wr(8'h12, 8'h10);
		lsbf_host_model_inst.wr(8'h10, 8'h7f);
		repeat (203 * TC) @(negedge clk_in);
		check(16'(lit[4:0]), 16'h1b);
		check(16'(lit[6:5]), 16'h2);
		// ========
		// Steady on, then fades
		lsbf_host_model_inst.wr(8'h12, 8'h00);
		lsbf_host_model_inst.wr(8'h10, 8'h01);
		repeat (3) @(negedge clk_in);
		span(1'b1, n);
		check(16'(n), 16'h1f40);
		check(16'(level[6:0]), 16'h7f);
		lsbf_host_model_inst.wr(8'h10, 8'h00);
		lsbf_host_model_inst.wr(8'h13, 8'ha1);
		lsbf_host_model_inst.wr(8'h10, 8'h01);
		ramp(7'h7f, n);
		near(n, 300 * TC);
		lsbf_host_model_inst.wr(8'h10, 8'h00);
		ramp(7'h00, n);
		near(n, 3000 * TC);
		lsbf_host_model_inst.wr(8'h13, 8'h11);
		lsbf_host_model_inst.wr(8'h10, 8'h01);
		ramp(7'h40, n);
		lsbf_host_model_inst.wr(8'h10, 8'h00);
		ramp(7'h00, n);
		near(n, 64 * 300 * TC / 127);
		conclude();
	end
endmodule : lsbf_sink_timing_tb
